// ===== shared/tx_dbg_params.svh
// Offsets, field positions and reset values of the debug/attribute bank.
// Assumes byte addresses on a 32-bit AXI4-Lite bus.
`ifndef TX_DBG_PARAMS_SVH
`define TX_DBG_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_TX_LEVEL      8'h78
`define OFS_TX_POINTER    8'h7c
`define OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES       8'ha0
`define OFS_FULL_SPEED_DESCRIPTOR_ATTRIBUTES       8'ha4
`define OFS_STR_ATTR      8'ha8
`define OFS_DESC_CTRL     8'hb8

// ****************************************************************
// Field positions
// ****************************************************************
`define POS_RD_FIELD      16
`define POS_POLL          16
`define POS_DEV_LEN       8
`define POS_CFG_LEN       0
`define POS_CFGSTR        24
`define POS_SERSTR        16
`define POS_PRODSTR       8
`define POS_MAKER         0
`define POS_EMU_EN        0

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define RST_HS_POLL       8'h04
`define RST_FS_POLL       8'h01
`define RST_LEN           8'h00
`define MASK_SPEED_ATTR   32'h00ffffff
`define MASK_STR_ATTR     32'hffffffff
`define MASK_DESC_CTRL    32'h00000001

// ****************************************************************
// AXI responses
// ****************************************************************
`define RESP_OKAY         2'b00
`define RESP_DECERR       2'b11

`endif

// ===== shared/tx_dbg_pkg.sv
// Types shared by the debug/attribute bank and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package tx_dbg_pkg;

  // ****************************************************************
  // FIFO side events, all one-cycle pulses on aclk
  // ****************************************************************
  typedef struct packed {
    logic wr_dword;     // One DWORD stored
    logic wr_commit;    // Whole packet now stored
    logic wr_error;     // Stored packet bad, rewind it
    logic rd_dword;     // One DWORD drained
    logic rd_done;      // Whole packet drained
  } tx_fifo_events_t;

  // ****************************************************************
  // Descriptor attributes handed to enumeration logic
  // ****************************************************************
  typedef struct packed {
    logic [7:0] high_speed_poll_interval;
    logic [7:0] high_speed_device_desc_len;
    logic [7:0] high_speed_config_desc_len;
    logic [7:0] full_speed_poll_interval;
    logic [7:0] full_speed_device_desc_len;
    logic [7:0] full_speed_config_desc_len;
    logic [7:0] config_string_len;
    logic [7:0] serial_string_len;
    logic [7:0] product_string_len;
    logic [7:0] maker_string_len;
  } desc_attr_t;

endpackage

// ===== rtl/tx_fifo_debug_and_descriptor_attrs.sv
// Transmit FIFO level/pointer tracking and descriptor attribute bank.
// Assumes FIFO events come from logic on aclk; one AXI4-Lite master.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tx_dbg_params.svh"

// What this block does
// - Read level grows by packet DWORD count once whole packet is stored.
// - Read level drops by one for each DWORD drained.
// - No read-side rewind; drained DWORDs never return to read level.
// - Write level grows by one for each DWORD stored.
// - Write level drops by packet DWORD count once packet fully drained.
// - Write rewind drops write level by DWORDs of partial packet so far.
// - A packet stored with error is rewound so the host resends it.
// - Read and write pointers readable as DWORD addresses, reset to zero.
// - High-speed poll interval bits 23:16, writable, resets to 04h.
// - Full-speed poll interval bits 23:16, writable, resets to 01h.
// - Four writable string sizes in one register, each resetting to zero.
// - Attributes drive descriptors only without EEPROM and emulation set.
// - Attributes keep contents across protected resets.
// - Size fields give lengths of descriptor images in descriptor RAM.
module tx_fifo_debug_and_descriptor_attrs #(
  parameter int LEVEL_W = 12,
  parameter int PTR_W   = 11
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        reset_protect,
  input  wire logic                        eeprom_present,
  input  wire tx_dbg_pkg::tx_fifo_events_t fifo_events,
  output      logic                        attrs_active,
  output      tx_dbg_pkg::desc_attr_t      desc_attrs,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output      logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output      logic                        s_axi_wready,
  output      logic [1:0]                  s_axi_bresp,
  output      logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output      logic                        s_axi_arready,
  output      logic [31:0]                 s_axi_rdata,
  output      logic [1:0]                  s_axi_rresp,
  output      logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Field widths are fixed by the register layout
  if (LEVEL_W < 1 || LEVEL_W > 12 || PTR_W < 1 || PTR_W > 11) begin : g_chk
    $error("LEVEL_W must be 1..12 and PTR_W 1..11");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~(lanes & mask)) | (data & lanes & mask);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [LEVEL_W-1:0] tx_read_level;
  logic [LEVEL_W-1:0] tx_write_level;
  logic [PTR_W-1:0]   tx_read_pointer;
  logic [PTR_W-1:0]   tx_write_pointer;
  logic [LEVEL_W-1:0] wr_pkt_count;
  logic [LEVEL_W-1:0] rd_pkt_count;
  logic [31:0]        high_speed_descriptor_attributes;
  logic [31:0]        full_speed_descriptor_attributes;
  logic [31:0]        str_attr;
  logic               eeprom_emulation_enable;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;

  // ****************************************************************
  // FIFO event arithmetic
  // ****************************************************************
  logic               wr_take;
  logic [LEVEL_W-1:0] wr_pkt_total;
  logic [LEVEL_W-1:0] rd_pkt_total;
  logic [LEVEL_W-1:0] next_read_level;
  logic [LEVEL_W-1:0] next_write_level;

  // A DWORD arriving in the error cycle belongs to the dropped packet
  assign wr_take = fifo_events.wr_dword & ~fifo_events.wr_error;
  // Totals include a DWORD that moves in the same cycle as the end
  assign wr_pkt_total = wr_pkt_count + LEVEL_W'(wr_take);
  assign rd_pkt_total = rd_pkt_count + LEVEL_W'(fifo_events.rd_dword);

  // Net adjustment of both levels in one step
  always_comb begin
    next_read_level = tx_read_level;
    if (fifo_events.wr_commit && !fifo_events.wr_error)
      next_read_level = next_read_level + wr_pkt_total;
    if (fifo_events.rd_dword)
      next_read_level = next_read_level - LEVEL_W'(1);
    // Nothing ever adds drained DWORDs back here
    next_write_level = tx_write_level;
    if (wr_take)
      next_write_level = next_write_level + LEVEL_W'(1);
    if (fifo_events.wr_error)
      next_write_level = next_write_level - wr_pkt_count;
    if (fifo_events.rd_done)
      next_write_level = next_write_level - rd_pkt_total;
  end

  // Level registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_read_level  <= '0;
      tx_write_level <= '0;
    end else begin
      tx_read_level  <= next_read_level;
      tx_write_level <= next_write_level;
    end
  end

  // Per-packet DWORD counters on both sides
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_pkt_count <= '0;
      rd_pkt_count <= '0;
    end else begin
      if (fifo_events.wr_error || fifo_events.wr_commit)
        wr_pkt_count <= '0;
      else if (wr_take)
        wr_pkt_count <= wr_pkt_count + LEVEL_W'(1);
      if (fifo_events.rd_done)
        rd_pkt_count <= '0;
      else if (fifo_events.rd_dword)
        rd_pkt_count <= rd_pkt_count + LEVEL_W'(1);
    end
  end

  // Pointers; the write pointer steps back over a bad packet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_read_pointer  <= '0;
      tx_write_pointer <= '0;
    end else begin
      if (fifo_events.rd_dword)
        tx_read_pointer <= tx_read_pointer + PTR_W'(1);
      if (fifo_events.wr_error)
        tx_write_pointer <= tx_write_pointer
                            - PTR_W'(wr_pkt_count);
      else if (wr_take)
        tx_write_pointer <= tx_write_pointer + PTR_W'(1);
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // Address and data are caught separately, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; debug registers accept and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case ({aw_addr[7:2], 2'b00})
        `OFS_TX_LEVEL, `OFS_TX_POINTER, `OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES, `OFS_FULL_SPEED_DESCRIPTOR_ATTRIBUTES,
        `OFS_STR_ATTR, `OFS_DESC_CTRL: s_axi_bresp <= `RESP_OKAY;
        default:                       s_axi_bresp <= `RESP_DECERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Attribute registers
  // ****************************************************************
  // Software is trusted to keep size fields legal and zero for absent
  // descriptors, and to leave them alone with an EEPROM fitted: no
  // checking here, the stored value is passed on as is.
  logic attr_reset;
  assign attr_reset = !aresetn && !reset_protect;

  // Protected attribute storage
  always_ff @(posedge aclk) begin
    if (attr_reset) begin
      high_speed_descriptor_attributes  <= {8'h00, `RST_HS_POLL, `RST_LEN, `RST_LEN};
      full_speed_descriptor_attributes  <= {8'h00, `RST_FS_POLL, `RST_LEN, `RST_LEN};
      str_attr <= {4{`RST_LEN}};
    end else if (aresetn && do_write) begin
      if ({aw_addr[7:2], 2'b00} == `OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES)
        high_speed_descriptor_attributes <= merge(high_speed_descriptor_attributes, w_data, w_strb,
                         `MASK_SPEED_ATTR);
      if ({aw_addr[7:2], 2'b00} == `OFS_FULL_SPEED_DESCRIPTOR_ATTRIBUTES)
        full_speed_descriptor_attributes <= merge(full_speed_descriptor_attributes, w_data, w_strb,
                         `MASK_SPEED_ATTR);
      if ({aw_addr[7:2], 2'b00} == `OFS_STR_ATTR)
        str_attr <= merge(str_attr, w_data, w_strb,
                          `MASK_STR_ATTR);
    end
  end

  // Descriptor source control, cleared by every reset
  always_ff @(posedge aclk) begin
    if (!aresetn)
      eeprom_emulation_enable <= 1'b0;
    else if (do_write && w_strb[0]
             && {aw_addr[7:2], 2'b00} == `OFS_DESC_CTRL)
      eeprom_emulation_enable <= w_data[`POS_EMU_EN];
  end

  // ****************************************************************
  // Attribute hand-off to descriptor processing
  // ****************************************************************
  // Registered so the enumeration logic sees no write glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attrs_active <= 1'b0;
      desc_attrs   <= '0;
    end else begin
      attrs_active <= !eeprom_present
                      && eeprom_emulation_enable;
      if (!eeprom_present && eeprom_emulation_enable) begin
        desc_attrs.high_speed_poll_interval   <= high_speed_descriptor_attributes[23:16];
        desc_attrs.high_speed_device_desc_len <= high_speed_descriptor_attributes[15:8];
        desc_attrs.high_speed_config_desc_len <= high_speed_descriptor_attributes[7:0];
        desc_attrs.full_speed_poll_interval   <= full_speed_descriptor_attributes[23:16];
        desc_attrs.full_speed_device_desc_len <= full_speed_descriptor_attributes[15:8];
        desc_attrs.full_speed_config_desc_len <= full_speed_descriptor_attributes[7:0];
        desc_attrs.config_string_len  <= str_attr[31:24];
        desc_attrs.serial_string_len  <= str_attr[23:16];
        desc_attrs.product_string_len <= str_attr[15:8];
        desc_attrs.maker_string_len   <= str_attr[7:0];
      end else begin
        desc_attrs <= '0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [31:0] read_word;
  logic        read_hit;

  assign s_axi_arready = !s_axi_rvalid;

  // Read mux; reserved bits come back as zero
  always_comb begin
    read_word = 32'h0;
    read_hit  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `OFS_TX_LEVEL: begin
        read_word[`POS_RD_FIELD +: LEVEL_W] = tx_read_level;
        read_word[0 +: LEVEL_W]             = tx_write_level;
      end
      `OFS_TX_POINTER: begin
        read_word[`POS_RD_FIELD +: PTR_W] = tx_read_pointer;
        read_word[0 +: PTR_W]             = tx_write_pointer;
      end
      `OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES:   read_word = high_speed_descriptor_attributes;
      `OFS_FULL_SPEED_DESCRIPTOR_ATTRIBUTES:   read_word = full_speed_descriptor_attributes;
      `OFS_STR_ATTR:  read_word = str_attr;
      `OFS_DESC_CTRL: read_word[`POS_EMU_EN] = eeprom_emulation_enable;
      default:        read_hit = 1'b0;
    endcase
  end

  // Read data held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_word;
      s_axi_rresp  <= read_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tx_fifo_debug_and_descriptor_attrs

// ===== test/tx_dbg_checker.sv
// Assertions on the ports of the tx debug and attribute bank.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/1ns
`include "tx_dbg_params.svh"
module tx_dbg_checker #(
  parameter int LEVEL_W = 12,
  parameter int PTR_W   = 11
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        reset_protect,
  input wire logic                        eeprom_present,
  input wire tx_dbg_pkg::tx_fifo_events_t fifo_events,
  input wire logic                        attrs_active,
  input wire tx_dbg_pkg::desc_attr_t      desc_attrs,
  input wire logic [7:0]                  s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic [3:0]                  s_axi_wstrb,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [7:0]                  s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready
);
  logic [7:0] rd_addr;

  // Address of the read in flight, so read data can be judged
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_gate_off:
    assert property (eeprom_present |=> !attrs_active)
    else $error("attributes active with eeprom fitted");
  chk_attr_cleared:
    assert property (eeprom_present [*2] |=> desc_attrs == '0)
    else $error("attribute outputs not cleared");
  chk_read_turn:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_r_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken while busy");
  chk_decerr_zero:
    assert property (s_axi_rvalid && s_axi_rresp == `RESP_DECERR |->
      s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
  chk_level_rsvd:
    assert property (s_axi_rvalid && rd_addr == `OFS_TX_LEVEL |->
      s_axi_rdata[31:28] == 4'h0 && s_axi_rdata[15:12] == 4'h0)
    else $error("level reserved bits set");
  chk_ptr_rsvd:
    assert property (s_axi_rvalid && rd_addr == `OFS_TX_POINTER |->
      s_axi_rdata[31:27] == 5'h0 && s_axi_rdata[15:11] == 5'h0)
    else $error("pointer reserved bits set");
  chk_speed_rsvd:
    assert property (s_axi_rvalid && (rd_addr == `OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES ||
      rd_addr == `OFS_FULL_SPEED_DESCRIPTOR_ATTRIBUTES) |-> s_axi_rdata[31:24] == 8'h0)
    else $error("speed attribute reserved bits set");
  chk_write_turn:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles on");
  chk_b_retire:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired once taken");

  // Main scenarios reached
  cover property (attrs_active);
  cover property (s_axi_rvalid && s_axi_rresp == `RESP_DECERR);
  cover property (s_axi_bvalid && s_axi_bresp == `RESP_OKAY);
endmodule // tx_dbg_checker

bind tx_fifo_debug_and_descriptor_attrs tx_dbg_checker #(
  .LEVEL_W(LEVEL_W), .PTR_W(PTR_W)
) tx_dbg_checker_inst (.aclk, .aresetn, .reset_protect, .eeprom_present,
  .fifo_events, .attrs_active, .desc_attrs, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== test/tx_fifo_debug_and_descriptor_attrs_tb.sv
// Self-checking bench for the tx debug and attribute bank.
// Assumes the checker file is compiled with it and binds itself.
`timescale 1ns/1ns
`include "tx_dbg_params.svh"
module tx_fifo_debug_and_descriptor_attrs_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] rst;
    logic [31:0] aft;
  } row_t;
  // Event codes: wr_dword, wr_commit, wr_error, rd_dword, rd_done
  localparam logic [4:0] WD = 5'h10, CM = 5'h08, ER = 5'h04, RD = 5'h02;
  localparam logic [4:0] DN = 5'h01;
  logic                        aclk, aresetn, reset_protect, eeprom_present;
  tx_dbg_pkg::tx_fifo_events_t fifo_events;
  logic                        attrs_active;
  tx_dbg_pkg::desc_attr_t      desc_attrs;
  logic [7:0]                  s_axi_awaddr, s_axi_araddr;
  logic [31:0]                 s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]                  s_axi_wstrb, wr_strb;
  logic [1:0]                  s_axi_bresp, s_axi_rresp, resp;
  logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                        s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                        s_axi_rready;
  int                          fail_count, n_checks;
  row_t                        rows [5];

  tx_fifo_debug_and_descriptor_attrs tx_fifo_debug_and_descriptor_attrs_inst (
    .aclk, .aresetn, .reset_protect, .eeprom_present, .fifo_events,
    .attrs_active, .desc_attrs, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 10 MHz clock
  always #50 aclk = ~aclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= wr_strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_d && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_d;
    ar_d = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_d && s_axi_arready) begin
        ar_d = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic ev(input logic [4:0] e);
    @(posedge aclk);
    fifo_events <= e;
  endtask

  // Protection level is seen at the same edges as the reset
  task automatic do_reset(input logic prot);
    @(posedge aclk);
    reset_protect <= prot;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    aclk = 0; aresetn = 0; reset_protect = 0; eeprom_present = 0;
    fifo_events = '0; s_axi_awaddr = '0; s_axi_araddr = '0;
    s_axi_wdata = '0; s_axi_wstrb = '0; s_axi_awvalid = 0;
    s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    fail_count = 0; n_checks = 0;
    wr_strb = 4'hf;
    rows[0] = '{`OFS_TX_LEVEL, 32'hffffffff, 32'h0, 32'h0};
    rows[1] = '{`OFS_TX_POINTER, 32'hffffffff, 32'h0, 32'h0};
    rows[2] = '{`OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES, 32'hff0a1212, 32'h00040000, 32'h000a1212};
    rows[3] = '{`OFS_FULL_SPEED_DESCRIPTOR_ATTRIBUTES, 32'h00200012, 32'h00010000, 32'h00200012};
    rows[4] = '{`OFS_STR_ATTR, 32'h11223344, 32'h0, 32'h11223344};
    do_reset(1'b0);
    foreach (rows[i]) begin
      axi_rd(rows[i].a, rdat, resp);
      check(rdat, rows[i].rst);
      axi_wr(rows[i].a, rows[i].w, resp);
      check({30'h0, resp}, {30'h0, `RESP_OKAY});
      axi_rd(rows[i].a, rdat, resp);
      check(rdat, rows[i].aft);
    end
    // Unmapped places answer with an error and hold nothing
    axi_rd(8'h80, rdat, resp);
    check({30'h0, resp}, {30'h0, `RESP_DECERR});
    axi_wr(8'h84, 32'hffffffff, resp);
    check({30'h0, resp}, {30'h0, `RESP_DECERR});
    // Emulation on, then an eeprom appears and must win
    axi_wr(`OFS_DESC_CTRL, 32'h1, resp);
    repeat (3) @(posedge aclk);
    check({31'h0, attrs_active}, 32'h1);
    check(desc_attrs[79:48], 32'h0a121220);
    check(desc_attrs[47:16], 32'h00121122);
    check({16'h0, desc_attrs[15:0]}, 32'h3344);
    eeprom_present <= 1'b1;
    repeat (3) @(posedge aclk);
    check({31'h0, attrs_active}, 32'h0);
    check(desc_attrs[79:48], 32'h0);
    eeprom_present <= 1'b0;
    // Partial packet, then commit together with its last DWORD
    ev(WD); ev(WD); ev(5'h0);
    axi_rd(`OFS_TX_LEVEL, rdat, resp);
    check(rdat, 32'h00000002);
    ev(WD | CM); ev(5'h0);
    axi_rd(`OFS_TX_LEVEL, rdat, resp);
    check(rdat, 32'h00030003);
    ev(RD); ev(RD); ev(5'h0);
    axi_rd(`OFS_TX_LEVEL, rdat, resp);
    check(rdat, 32'h00010003);
    ev(RD | DN); ev(5'h0);
    axi_rd(`OFS_TX_LEVEL, rdat, resp);
    check(rdat, 32'h0);
    // Bad packet is rewound out of the write side
    ev(WD); ev(WD); ev(ER); ev(5'h0);
    axi_rd(`OFS_TX_LEVEL, rdat, resp);
    check(rdat, 32'h0);
    axi_rd(`OFS_TX_POINTER, rdat, resp);
    check(rdat, 32'h00030003);
    // Protected reset keeps attributes, plain reset restores them
    do_reset(1'b1);
    axi_rd(`OFS_STR_ATTR, rdat, resp);
    check(rdat, 32'h11223344);
    // Only the strobed byte lane of a write lands
    wr_strb = 4'h2;
    axi_wr(`OFS_STR_ATTR, 32'haabbccdd, resp);
    wr_strb = 4'hf;
    axi_rd(`OFS_STR_ATTR, rdat, resp);
    check(rdat, 32'h1122cc44);
    axi_rd(`OFS_TX_POINTER, rdat, resp);
    check(rdat, 32'h0);
    do_reset(1'b0);
    axi_rd(`OFS_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES, rdat, resp);
    check(rdat, 32'h00040000);
    axi_rd(`OFS_STR_ATTR, rdat, resp);
    check(rdat, 32'h0);
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge aclk);
    fail_count++;
    end_sim();
  end
endmodule // tx_fifo_debug_and_descriptor_attrs_tb
